/* File: src/tkc_pkg.sv */
package tkc_pkg;

    // =========================================================================
    // Command codes and fixed answers.
    localparam logic [7:0] CMD_TOUCH_GRP = 8'h4B;
    localparam logic [7:0] CMD_NTHR      = 8'h01;
    localparam logic [7:0] CMD_PTHR      = 8'h02;
    localparam logic [7:0] CMD_NHYS      = 8'h03;
    localparam logic [7:0] CMD_PHYS      = 8'h04;
    localparam logic [7:0] CMD_DWELL     = 8'h05;
    localparam logic [7:0] CMD_BURST     = 8'h06;
    localparam logic [7:0] CMD_SPACING   = 8'h07;
    localparam logic [7:0] DWELL_FIXED   = 8'h01;
    localparam int         NKEYS         = 64;

    // =========================================================================
    // Setting limits, lists and reset values.
    localparam logic [1:0] HYS_MAX     = 2'h3;
    localparam logic [2:0] SPC_MAX     = 3'h5;
    localparam logic [7:0] THR_RST     = 8'h0A;
    localparam logic [7:0] BURST_RST   = 8'h0A;
    localparam logic [1:0] HYS_RST     = 2'h1;
    localparam logic [2:0] SPC_RST     = 3'h3;
    localparam logic [7:0] THR_LIST [16] = '{8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h0A, 8'h0C, 8'h0F, 8'h11, 8'h14, 8'h19, 8'h1E, 8'h23,
        8'h2D, 8'h37, 8'h40};
    localparam logic [7:0] BURST_LIST [16] = '{8'h00, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h05, 8'h07, 8'h0A, 8'h0C, 8'h0F, 8'h14, 8'h19, 8'h1E,
        8'h28, 8'h32, 8'h40};
    // Spacing in microseconds for codes 0..5.
    localparam logic [10:0] SPC_US [6] = '{11'h0FA, 11'h12C, 11'h190,
        11'h1F4, 11'h3E8, 11'h7D0};

    // =========================================================================
    // Storage write time.
    localparam int NVM_WRITE_US  = 5000;
    localparam int CLK_MHZ       = 200;
    localparam int NVM_WRITE_CYC = NVM_WRITE_US * CLK_MHZ;

    // =========================================================================
    // Types.
    typedef enum logic [1:0] {
        SC_KEY = 2'h0,
        SC_ROW = 2'h1,
        SC_COL = 2'h2,
        SC_ALL = 2'h3
    } tkc_scope_e;

    typedef struct packed {
        tkc_scope_e mode;
        logic [5:0] index;   // Bits 5:3 row (Y), bits 2:0 column (X).
    } tkc_scope_s;

    typedef struct packed {
        logic [7:0] nthr;
        logic [7:0] pthr;
        logic [7:0] burst;
        logic [7:0] nhys_lvl;
        logic [7:0] phys_lvl;
    } tkc_keycfg_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARG  = 4'h2,
        ST_SEND = 4'h4,
        ST_NVM  = 4'h8
    } tkc_state_e;

    // =========================================================================
    // Snaps a value down to the highest list entry not above it; values below the first entry give the first entry.
    function automatic logic [7:0] round_down(input logic [7:0] v,
                                              input logic [7:0] lst [16]);
        logic [7:0] r;
        r = lst[0];
        for (int i = 0; i < 16; i++) begin
            if (v >= lst[i]) begin
                r = lst[i];
            end
        end
        return r;
    endfunction

    // Hysteresis level in counts from the reference: threshold less a share.
    function automatic logic [7:0] hys_level(input logic [7:0] thr,
                                             input logic [1:0] code);
        logic [7:0] r;
        r = thr;
        unique case (code)
            2'h0: r = thr - (thr >> 1);
            2'h1: r = thr - (thr >> 2);
            2'h2: r = thr - (thr >> 3);
            2'h3: r = thr;
        endcase
        return r;
    endfunction

endpackage

/* File: src/tkc_cmd_handler.sv */
`timescale 1ns/1ps
module tkc_cmd_handler #(
    parameter int WR_CYCLES = tkc_pkg::NVM_WRITE_CYC
) (
    // Clock, reset and enable.
    input  wire logic                 MCLK,
    input  wire logic                 ARST_N,
    input  wire logic                 CE,
    // Host byte link.
    input  wire logic                 RX_VALID,
    input  wire logic [7:0]           RX_DATA,
    input  wire logic                 RX_GET,
    output logic                      RX_READY,
    output logic                      TX_VALID,
    output logic [7:0]                TX_DATA,
    input  wire logic                 TX_READY,
    output logic                      NVM_BUSY,
    // Scope and sensing core.
    input  wire tkc_pkg::tkc_scope_s  SCOPE,
    input  wire logic [63:0]          TOUCH,
    input  wire logic [5:0]           CFG_KEY,
    output tkc_pkg::tkc_keycfg_s      CFG,
    output logic                      KEY_BURST_OFF,
    output logic [10:0]               SPACING_US
);

    localparam int CW = $clog2(WR_CYCLES + 1);

    // =========================================================================
    // Elaboration check.
    if (WR_CYCLES < 1) begin : g_chk
        $error("WR_CYCLES must be at least one");
    end

    // =========================================================================
    // State.
    tkc_pkg::tkc_state_e state_q, state_d;
    logic [7:0]          cmd_q, cmd_d;
    logic [7:0]          arg_q, arg_d;
    logic                pend_q, pend_d;
    logic [63:0]         buf_q, buf_d;
    logic [3:0]          cnt_q, cnt_d;
    logic [CW-1:0]       wait_q, wait_d;
    logic [7:0]          nthr_q [tkc_pkg::NKEYS];
    logic [7:0]          nthr_d [tkc_pkg::NKEYS];
    logic [7:0]          pthr_q [tkc_pkg::NKEYS];
    logic [7:0]          pthr_d [tkc_pkg::NKEYS];
    logic [7:0]          bur_q  [tkc_pkg::NKEYS];
    logic [7:0]          bur_d  [tkc_pkg::NKEYS];
    logic [1:0]          nhys_q, nhys_d;
    logic [1:0]          phys_q, phys_d;
    logic [2:0]          spc_q, spc_d;
    logic [63:0]         scope_hit;
    logic [7:0]          touch_byte;
    logic [7:0]          get_val;
    logic                is_setup;
    logic                apply;

    // Keys covered by the current scope.
    always_comb begin
        for (int k = 0; k < 64; k++) begin
            unique case (SCOPE.mode)
                tkc_pkg::SC_KEY: scope_hit[k] = (k[5:0] == SCOPE.index);
                tkc_pkg::SC_ROW: scope_hit[k] = (k[5:3] == SCOPE.index[5:3]);
                tkc_pkg::SC_COL: scope_hit[k] = (k[2:0] == SCOPE.index[2:0]);
                tkc_pkg::SC_ALL: scope_hit[k] = 1'b1;
            endcase
        end
    end

    // One-byte touch view for key, row and column scopes.
    always_comb begin
        touch_byte = 8'h00;
        unique case (SCOPE.mode)
            tkc_pkg::SC_KEY: touch_byte = {7'h00, TOUCH[SCOPE.index]};
            tkc_pkg::SC_ROW: touch_byte = TOUCH[{SCOPE.index[5:3], 3'h0} +: 8];
            tkc_pkg::SC_COL: begin
                for (int n = 0; n < 8; n++) begin
                    touch_byte[n] = TOUCH[{n[2:0], SCOPE.index[2:0]}];
                end
            end
            tkc_pkg::SC_ALL: touch_byte = TOUCH[7:0];
        endcase
    end

    // Value returned by a setup read for the selected key or globally.
    always_comb begin
        is_setup = (RX_DATA >= tkc_pkg::CMD_NTHR) &&
                   (RX_DATA <= tkc_pkg::CMD_SPACING);
        get_val  = 8'h00;
        unique case (RX_DATA)
            tkc_pkg::CMD_NTHR:    get_val = nthr_q[SCOPE.index];
            tkc_pkg::CMD_PTHR:    get_val = pthr_q[SCOPE.index];
            tkc_pkg::CMD_NHYS:    get_val = {6'h00, nhys_q};
            tkc_pkg::CMD_PHYS:    get_val = {6'h00, phys_q};
            tkc_pkg::CMD_DWELL:   get_val = tkc_pkg::DWELL_FIXED;
            tkc_pkg::CMD_BURST:   get_val = bur_q[SCOPE.index];
            tkc_pkg::CMD_SPACING: get_val = {5'h00, spc_q};
            default:              get_val = 8'h00;
        endcase
    end

    // =========================================================================
    // Command sequencer: take command, take argument, answer, wait storage.
    always_comb begin
        state_d = state_q;
        cmd_d   = cmd_q;
        arg_d   = arg_q;
        pend_d  = pend_q;
        buf_d   = buf_q;
        cnt_d   = cnt_q;
        wait_d  = wait_q;
        apply   = 1'b0;
        unique case (state_q)
            tkc_pkg::ST_IDLE: begin
                if (RX_VALID && RX_DATA == tkc_pkg::CMD_TOUCH_GRP) begin
                    pend_d  = 1'b0;
                    state_d = tkc_pkg::ST_SEND;
                    if (SCOPE.mode == tkc_pkg::SC_ALL) begin
                        buf_d = TOUCH;
                        cnt_d = 4'h8;
                    end else begin
                        buf_d = {56'h0, touch_byte};
                        cnt_d = 4'h1;
                    end
                end else if (RX_VALID && is_setup) begin
                    cmd_d = RX_DATA;
                    if (RX_GET) begin
                        pend_d  = 1'b0;
                        buf_d   = {56'h0, get_val};
                        cnt_d   = 4'h1;
                        state_d = tkc_pkg::ST_SEND;
                    end else begin
                        state_d = tkc_pkg::ST_ARG;
                    end
                end
            end
            tkc_pkg::ST_ARG: begin
                if (RX_VALID) begin
                    arg_d   = RX_DATA;
                    pend_d  = 1'b1;
                    buf_d   = {56'h0, cmd_q};
                    cnt_d   = 4'h1;
                    state_d = tkc_pkg::ST_SEND;
                end
            end
            tkc_pkg::ST_SEND: begin
                if (TX_READY) begin
                    buf_d = {8'h00, buf_q[63:8]};
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        apply   = pend_q;
                        wait_d  = CW'(WR_CYCLES - 1);
                        state_d = pend_q ? tkc_pkg::ST_NVM
                                         : tkc_pkg::ST_IDLE;
                    end
                end
            end
            tkc_pkg::ST_NVM: begin
                if (wait_q == '0) begin
                    state_d = tkc_pkg::ST_IDLE;
                end else begin
                    wait_d = wait_q - CW'(1);
                end
            end
            default: state_d = tkc_pkg::ST_IDLE;
        endcase
    end

    // Registers of the sequencer and the host-facing outputs.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q  <= tkc_pkg::ST_IDLE;
            cmd_q    <= 8'h00;
            arg_q    <= 8'h00;
            pend_q   <= 1'b0;
            buf_q    <= 64'h0;
            cnt_q    <= 4'h0;
            wait_q   <= '0;
            RX_READY <= 1'b0;
            TX_VALID <= 1'b0;
            TX_DATA  <= 8'h00;
            NVM_BUSY <= 1'b0;
        end else if (CE) begin
            state_q  <= state_d;
            cmd_q    <= cmd_d;
            arg_q    <= arg_d;
            pend_q   <= pend_d;
            buf_q    <= buf_d;
            cnt_q    <= cnt_d;
            wait_q   <= wait_d;
            RX_READY <= (state_d == tkc_pkg::ST_IDLE) ||
                        (state_d == tkc_pkg::ST_ARG);
            TX_VALID <= (state_d == tkc_pkg::ST_SEND);
            TX_DATA  <= buf_d[7:0];
            NVM_BUSY <= (state_d == tkc_pkg::ST_NVM);
        end
    end

    // =========================================================================
    // Setting store: applied on the echo, sensing outputs never pause.
    always_comb begin
        nthr_d = nthr_q;
        pthr_d = pthr_q;
        bur_d  = bur_q;
        nhys_d = nhys_q;
        phys_d = phys_q;
        spc_d  = spc_q;
        if (apply) begin
            for (int k = 0; k < 64; k++) begin
                if (scope_hit[k] && cmd_q == tkc_pkg::CMD_NTHR) begin
                    nthr_d[k] = tkc_pkg::round_down(arg_q,
                                    tkc_pkg::THR_LIST);
                end
                if (scope_hit[k] && cmd_q == tkc_pkg::CMD_PTHR) begin
                    pthr_d[k] = tkc_pkg::round_down(arg_q,
                                    tkc_pkg::THR_LIST);
                end
                if (scope_hit[k] && cmd_q == tkc_pkg::CMD_BURST) begin
                    bur_d[k] = tkc_pkg::round_down(arg_q,
                                   tkc_pkg::BURST_LIST);
                end
            end
            if (cmd_q == tkc_pkg::CMD_NHYS) begin
                nhys_d = (arg_q > 8'h03) ? tkc_pkg::HYS_MAX : arg_q[1:0];
            end
            if (cmd_q == tkc_pkg::CMD_PHYS) begin
                phys_d = (arg_q > 8'h03) ? tkc_pkg::HYS_MAX : arg_q[1:0];
            end
            if (cmd_q == tkc_pkg::CMD_SPACING) begin
                spc_d = (arg_q > 8'h05) ? tkc_pkg::SPC_MAX : arg_q[2:0];
            end
        end
    end

    // Setting registers and the per-key view for the sensing core.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int k = 0; k < 64; k++) begin
                nthr_q[k] <= tkc_pkg::THR_RST;
                pthr_q[k] <= tkc_pkg::THR_RST;
                bur_q[k]  <= tkc_pkg::BURST_RST;
            end
            nhys_q        <= tkc_pkg::HYS_RST;
            phys_q        <= tkc_pkg::HYS_RST;
            spc_q         <= tkc_pkg::SPC_RST;
            CFG           <= '0;
            KEY_BURST_OFF <= 1'b0;
            SPACING_US    <= 11'h000;
        end else if (CE) begin
            nthr_q        <= nthr_d;
            pthr_q        <= pthr_d;
            bur_q         <= bur_d;
            nhys_q        <= nhys_d;
            phys_q        <= phys_d;
            spc_q         <= spc_d;
            CFG.nthr      <= nthr_q[CFG_KEY];
            CFG.pthr      <= pthr_q[CFG_KEY];
            CFG.burst     <= bur_q[CFG_KEY];
            CFG.nhys_lvl  <= tkc_pkg::hys_level(nthr_q[CFG_KEY],
                                                nhys_q);
            CFG.phys_lvl  <= tkc_pkg::hys_level(pthr_q[CFG_KEY],
                                                phys_q);
            KEY_BURST_OFF <= (bur_q[CFG_KEY] == 8'h00);
            SPACING_US    <= tkc_pkg::SPC_US[spc_q];
        end
    end

    // =========================================================================
    // Checks on the answers and stored settings.
    logic idle_take;
    assign idle_take = CE && state_q == tkc_pkg::ST_IDLE && RX_VALID;

    touch_len_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_DATA == tkc_pkg::CMD_TOUCH_GRP &&
        SCOPE.mode == tkc_pkg::SC_ALL |=> cnt_q == 4'h8 && TX_VALID)
        else $error("whole-matrix report is not eight bytes");
    key_bit_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_DATA == tkc_pkg::CMD_TOUCH_GRP &&
        SCOPE.mode == tkc_pkg::SC_KEY
        |=> TX_DATA == {7'h00, $past(TOUCH[SCOPE.index])})
        else $error("single-key report byte is wrong");
    row_bits_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_DATA == tkc_pkg::CMD_TOUCH_GRP &&
        SCOPE.mode == tkc_pkg::SC_ROW
        |=> TX_DATA == $past(8'(TOUCH >> (8 * SCOPE.index[5:3]))))
        else $error("row report byte is wrong");
    all_first_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_DATA == tkc_pkg::CMD_TOUCH_GRP &&
        SCOPE.mode == tkc_pkg::SC_ALL |=> TX_DATA == $past(TOUCH[7:0]))
        else $error("first matrix byte is not row zero");
    echo_put_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        CE && state_q == tkc_pkg::ST_ARG && RX_VALID
        |=> TX_VALID && TX_DATA == cmd_q && pend_q)
        else $error("setup write is not echoed");
    dwell_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_GET && RX_DATA == tkc_pkg::CMD_DWELL
        |=> TX_DATA == tkc_pkg::DWELL_FIXED)
        else $error("dwell read is not one");
    thr_range_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        nthr_q[CFG_KEY] >= 8'h04 && nthr_q[CFG_KEY] <= 8'h40 &&
        CFG.nhys_lvl <= CFG.nthr)
        else $error("threshold or hysteresis out of range");
    burst_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        CE |=> KEY_BURST_OFF == ($past(bur_q[CFG_KEY]) == 8'h00))
        else $error("burst-off flag does not match burst length");
    spc_clip_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        CE && spc_q == tkc_pkg::SPC_MAX |=> SPACING_US == 11'h7D0)
        else $error("top spacing code is not 2000 us");
    nvm_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
        CE && state_q == tkc_pkg::ST_NVM && wait_q != '0
        |=> !RX_READY && NVM_BUSY)
        else $error("command taken during storage write");

    touch_all_c: cover property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_DATA == tkc_pkg::CMD_TOUCH_GRP &&
        SCOPE.mode == tkc_pkg::SC_ALL);
    put_done_c: cover property (@(posedge MCLK) disable iff (!ARST_N)
        state_q == tkc_pkg::ST_NVM ##1 state_q == tkc_pkg::ST_IDLE);
    get_c: cover property (@(posedge MCLK) disable iff (!ARST_N)
        idle_take && RX_GET && is_setup);

endmodule

/* File: tb/tkc_host_model.sv */
`timescale 1ns/1ps
// ============================================================================
// Host side of the byte link: sends requests and collects answer bytes.
module tkc_host_model (
    // Clock.
    input  wire logic       MCLK,
    // Request side.
    output logic            RX_VALID,
    output logic [7:0]      RX_DATA,
    output logic            RX_GET,
    input  wire logic       RX_READY,
    input  wire logic       NVM_BUSY,
    // Answer side.
    input  wire logic       TX_VALID,
    input  wire logic [7:0] TX_DATA,
    output logic            TX_READY
);
    logic [7:0] rx_buf [8];
    int         n_rx;

    // Idle values at time zero.
    initial begin
        RX_VALID = 1'b0;
        RX_DATA  = 8'hA5;
        RX_GET   = 1'b0;
        TX_READY = 1'b0;
    end

    // Sends a command and an optional argument byte; rude skips the wait.
    task automatic send(input logic [7:0] cmd, input logic get,
                        input logic arg_en, input logic [7:0] arg,
                        input logic rude);
        int t;
        t = 0;
        do begin
            @(posedge MCLK);
            t++;
        end while (!rude && !(RX_READY === 1'b1 && NVM_BUSY === 1'b0)
                   && t < 5000);
        RX_VALID <= 1'b1;
        RX_DATA  <= cmd;
        RX_GET   <= get;
        @(posedge MCLK);
        if (arg_en) begin
            RX_DATA <= arg;
            @(posedge MCLK);
        end
        RX_VALID <= 1'b0;
        // A released data line shows the inverse of its last value.
        RX_DATA  <= arg_en ? ~arg : ~cmd;
    endtask

    // Collects n answer bytes while stalling the acknowledge at random.
    task automatic collect(input int n);
        int t;
        n_rx = 0;
        t    = 0;
        while (n_rx < n && t < 400) begin
            @(posedge MCLK);
            t++;
            if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
                rx_buf[n_rx] = TX_DATA;
                n_rx++;
            end
            TX_READY <= (n_rx < n) && ($urandom_range(0, 2) != 0);
        end
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench with a shadow copy of every stored setting.
module testbench;
    localparam int WR = 12;
    localparam logic [10:0] US_TAB [5] = '{11'h0FA, 11'h12C, 11'h190,
        11'h1F4, 11'h3E8};
    logic MCLK, ARST_N, CE, RX_VALID, RX_GET, RX_READY, TX_VALID, TX_READY;
    logic NVM_BUSY, KEY_BURST_OFF;
    logic [7:0]  RX_DATA, TX_DATA;
    logic [63:0] TOUCH;
    logic [5:0]  CFG_KEY;
    logic [10:0] SPACING_US;
    tkc_pkg::tkc_scope_s  SCOPE;
    tkc_pkg::tkc_keycfg_s CFG;
    logic [7:0] nthr [64], pthr [64], burst [64];
    logic [1:0] nh, ph;
    logic [2:0] spc;
    int         error_cnt, n_checks;

    // Design and host model.
    tkc_cmd_handler #(.WR_CYCLES(WR)) dut_u (
        .MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .RX_GET(RX_GET), .RX_READY(RX_READY),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
        .NVM_BUSY(NVM_BUSY), .SCOPE(SCOPE), .TOUCH(TOUCH),
        .CFG_KEY(CFG_KEY), .CFG(CFG), .KEY_BURST_OFF(KEY_BURST_OFF),
        .SPACING_US(SPACING_US));
    tkc_host_model host_u (
        .MCLK(MCLK), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .RX_GET(RX_GET), .RX_READY(RX_READY), .NVM_BUSY(NVM_BUSY),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY));

    // Snaps a value down to the highest listed entry not above it; values below the first entry give the first entry.
    function automatic logic [7:0] snap(input logic [7:0] v, input logic th);
        logic [7:0] r;
        r = th ? 8'h04 : 8'h00;
        for (int i = 0; i < 16; i++) begin
            r = (th && v >= tkc_pkg::THR_LIST[i]) ? tkc_pkg::THR_LIST[i] : r;
            r = (!th && v >= tkc_pkg::BURST_LIST[i]) ?
                tkc_pkg::BURST_LIST[i] : r;
        end
        return r;
    endfunction

    // Hysteresis level: threshold less 50, 25, 12.5 or 0 percent of it.
    function automatic logic [7:0] lvl(input logic [7:0] t, input logic [1:0] c);
        return (c == 2'h3) ? t : t - (t / (8'h02 << c));
    endfunction

    // Tells whether a key lies inside the current scope.
    function automatic logic in_scope(input logic [5:0] k);
        return (SCOPE.mode == tkc_pkg::SC_ALL) ||
            (SCOPE.mode == tkc_pkg::SC_ROW && k[5:3] == SCOPE.index[5:3]) ||
            (SCOPE.mode == tkc_pkg::SC_COL && k[2:0] == SCOPE.index[2:0]) ||
            (SCOPE.mode == tkc_pkg::SC_KEY && k == SCOPE.index);
    endfunction

    // Expected touch byte number b for the current scope.
    function automatic logic [7:0] exp_touch(input int b);
        logic [7:0] r, c;
        for (int i = 0; i < 8; i++) begin
            r[i] = TOUCH[{SCOPE.index[5:3], 3'(i)}];
            c[i] = TOUCH[{3'(i), SCOPE.index[2:0]}];
        end
        return (SCOPE.mode == tkc_pkg::SC_ALL) ? TOUCH[8*b +: 8] :
            (SCOPE.mode == tkc_pkg::SC_ROW) ? r :
            (SCOPE.mode == tkc_pkg::SC_COL) ? c : {7'h00, TOUCH[SCOPE.index]};
    endfunction

    // Compares one value and reports any difference.
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compares the settings shown for one key with the shadow copy.
    task automatic check_key(input logic [5:0] k);
        CFG_KEY <= k;
        repeat (2) @(posedge MCLK);
        chk(CFG, {nthr[k], pthr[k], burst[k], lvl(nthr[k], nh),
                  lvl(pthr[k], ph)});
        chk(40'(KEY_BURST_OFF), 40'(burst[k] == 8'h00));
        chk(40'(SPACING_US), (spc > 3'h4) ? 40'h7D0 : 40'(US_TAB[spc]));
    endtask

    // Writes one setting, checks echo, early effect and the storage wait.
    task automatic do_put(input logic [7:0] cmd, input logic [7:0] arg);
        int t;
        host_u.send(cmd, 1'b0, 1'b1, arg, 1'b0);
        host_u.collect(1);
        chk(40'(host_u.rx_buf[0]), 40'(cmd));
        for (int i = 0; i < 64; i++) begin
            nthr[i] = (cmd == 8'h01 && in_scope(6'(i))) ? snap(arg, 1) : nthr[i];
            pthr[i] = (cmd == 8'h02 && in_scope(6'(i))) ? snap(arg, 1) : pthr[i];
            burst[i] = (cmd == 8'h06 && in_scope(6'(i))) ? snap(arg, 0) : burst[i];
        end
        nh = (cmd == 8'h03) ? ((arg > 8'h03) ? 2'h3 : arg[1:0]) : nh;
        ph = (cmd == 8'h04) ? ((arg > 8'h03) ? 2'h3 : arg[1:0]) : ph;
        spc = (cmd == 8'h07) ? ((arg > 8'h05) ? 3'h5 : arg[2:0]) : spc;
        check_key(SCOPE.index);
        chk(40'({NVM_BUSY, RX_READY}), 40'h2);
        host_u.send(8'h4B, 1'b0, 1'b0, 8'h00, 1'b1);
        for (t = 3; NVM_BUSY === 1'b1 && t < 200; t++) @(posedge MCLK);
        chk(40'(t >= WR - 2 && t <= WR + 2), 40'h1);
        repeat (3) @(posedge MCLK);
        chk(40'({TX_VALID, RX_READY}), 40'h1);
        check_key(6'($urandom));
    endtask

    // Reads one setting and compares it with the shadow copy.
    task automatic do_get(input logic [7:0] cmd);
        logic [7:0] e;
        logic [5:0] k;
        k = SCOPE.index;
        e = (cmd == 8'h01) ? nthr[k] : (cmd == 8'h02) ? pthr[k] :
            (cmd == 8'h03) ? {6'h00, nh} : (cmd == 8'h04) ? {6'h00, ph} :
            (cmd == 8'h05) ? 8'h01 : (cmd == 8'h06) ? burst[k] : {5'h00, spc};
        host_u.send(cmd, 1'b1, 1'b0, 8'h00, 1'b0);
        host_u.collect(1);
        chk(40'(host_u.rx_buf[0]), 40'(e));
    endtask

    // Runs a touch query and checks every returned byte.
    task automatic do_touch();
        int         n;
        logic [7:0] m;
        n = (SCOPE.mode == tkc_pkg::SC_ALL) ? 8 : 1;
        m = (SCOPE.mode == tkc_pkg::SC_KEY) ? 8'h01 : 8'hFF;
        host_u.send(8'h4B, 1'($urandom), 1'b0, 8'h00, 1'b0);
        host_u.collect(n);
        chk(40'(host_u.n_rx), 40'(n));
        for (int b = 0; b < n; b++) begin
            chk(40'(host_u.rx_buf[b] & m), 40'(exp_touch(b) & m));
        end
    endtask

    // Clock of 5 ns period.
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    // Watchdog against a hung handshake.
    initial begin
        #200000;
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Main sequence: reset, corner writes and reads, then random traffic.
    initial begin
        error_cnt = 0;
        n_checks  = 0;
        {ARST_N, CE, SCOPE, TOUCH, CFG_KEY} = {1'b0, 1'b1, 8'hC0, 70'h0};
        void'($urandom(40058));
        for (int i = 0; i < 64; i++) {nthr[i], pthr[i], burst[i]} = 24'h0A0A0A;
        {nh, ph, spc} = {2'h1, 2'h1, 3'h3};
        repeat (20) @(posedge MCLK);
        ARST_N <= 1'b1;
        check_key(6'h15);
        $display("Test reset defaults done");
        foreach (US_TAB[i]) do_put(8'h07, 8'(i));
        do_put(8'h07, 8'h09);
        do_put(8'h01, 8'h03);
        do_put(8'h02, 8'hFF);
        do_put(8'h06, 8'h00);
        do_put(8'h03, 8'h07);
        do_put(8'h04, 8'h02);
        do_put(8'h05, 8'h09);
        for (int c = 1; c < 8; c++) do_get(8'(c));
        // A frozen clock enable and an unknown command both go unanswered.
        for (int i = 0; i < 2; i++) begin
            CE <= 1'(i);
            host_u.send(i ? 8'h4A : 8'h05, 1'b1, 1'b0, 8'h00, 1'b0);
            repeat (2) @(posedge MCLK);
            chk(40'({TX_VALID, RX_READY}), 40'h1);
        end
        CE <= 1'b1;
        $display("Test corner settings done");
        for (int i = 0; i < 60; i++) begin
            SCOPE <= tkc_pkg::tkc_scope_s'(8'($urandom));
            TOUCH <= {$urandom, $urandom};
            @(posedge MCLK);
            case ($urandom_range(0, 2))
                0: do_touch();
                1: do_put(8'($urandom_range(1, 7)), 8'($urandom));
                default: do_get(8'($urandom_range(1, 7)));
            endcase
        end
        $display("Test random traffic done");
        wrap_up();
    end
endmodule
